// file: hdl/sttk_host.sv
// Host controller driving a serial timekeeper through SRAM-style cycles.
// Assumes an AHB-Lite master on hclk and the device on its data lane 0.
//
// Notes on behaviour
// - Host always moves all 64 bits, never partial registers.
// - Time values are BCD in both directions; host passes words unchanged.
// - Bits go register 0 bit 0 first, register 7 bit 7 last.
// - Unlock key bytes are C5 3A A3 5C C5 3A A3 5C.
// - Each key byte is sent LSB first, one bit per write.
// - A read cycle restarts the key comparison at its first bit.
`timescale 1ns/100ps
`default_nettype none
module sttk_host
    import sttk_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int RECOV_CYCLES = RECOV_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic        ce_n,
    output var  logic        oe_n,
    output var  logic        we_n,
    output var  logic [12:0] mem_addr,
    output var  logic        dq0_out,
    output var  logic        dq0_oe,
    input  wire logic        dq0_in
);
    initial begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255 || RECOV_CYCLES < 1 || RECOV_CYCLES > 255)
            $error("sttk_host: cycle counts out of range");
    end

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_RDSET = 6'b000010,
        ST_KEY   = 6'b000100,
        ST_DATA  = 6'b001000,
        ST_RECOV = 6'b010000,
        ST_DONE  = 6'b100000
    } sttk_state_e;

    // ------------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------------
    logic        dq_s1_ff;
    logic        dq_s2_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_s1_ff <= 1'b0;
            dq_s2_ff <= 1'b0;
        end else begin
            dq_s1_ff <= dq0_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        ap_wr_ff;
    logic        ap_rd_ff;
    logic [7:0]  ap_ofs_ff;
    logic        mode_wr_ff;
    logic [63:0] wdata_ff;
    logic [63:0] rdata_ff;
    logic [12:0] addr_ff;
    logic        done_ff;
    sttk_state_e state_ff;

    wire         ap_valid = hsel && hready && htrans[1];
    wire         busy     = (state_ff != ST_IDLE);
    wire         wr_ctrl  = ap_wr_ff && (ap_ofs_ff == OFS_CTRL);
    wire         go       = wr_ctrl && hwdata[CTRL_GO_BIT] && !busy;
    wire [31:0]  status_w = {30'h0, done_ff, busy};

    function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
        case (ofs)
            OFS_CTRL:    rd_mux = {30'h0, mode_wr_ff, 1'b0};
            OFS_STATUS:  rd_mux = status_w;
            OFS_TIME_LO: rd_mux = rdata_ff[31:0];
            OFS_TIME_HI: rd_mux = rdata_ff[63:32];
            OFS_ADDR:    rd_mux = {19'h0, addr_ff};
            default:     rd_mux = RST_ZERO;
        endcase
    endfunction : rd_mux

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_ff  <= 1'b0;
            ap_rd_ff  <= 1'b0;
            ap_ofs_ff <= 8'h00;
            hrdata    <= RST_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ap_wr_ff  <= ap_valid && hwrite;
            ap_rd_ff  <= ap_valid && !hwrite;
            ap_ofs_ff <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata <= rd_mux(haddr[7:0]);
        end
    end

    // Writable shadow registers (time words refuse writes while busy)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_wr_ff <= 1'b0;
            wdata_ff   <= {RST_ZERO, RST_ZERO};
            addr_ff    <= RST_ADDR;
        end else if (ap_wr_ff && !busy) begin
            case (ap_ofs_ff)
                OFS_CTRL:    mode_wr_ff <= hwdata[CTRL_WRITE_BIT];
                OFS_TIME_LO: wdata_ff[31:0] <= hwdata;
                OFS_TIME_HI: wdata_ff[63:32] <= hwdata;
                OFS_ADDR:    addr_ff <= hwdata[12:0];
                default:     mode_wr_ff <= mode_wr_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------------
    logic [5:0]  bit_ff;
    // Stream stage: 0 read set-up, 1 key, 2 data
    logic [1:0]  stage_ff;
    logic [7:0]  tick_ff;
    logic        phase_ff;
    logic        is_rd_cyc;
    logic        cur_bit;

    wire         tick_end  = (tick_ff == 8'h00);
    wire         last_bit  = (bit_ff == 6'(FRAME_BITS - 1));
    wire         key_bit   = UNLOCK_KEY[bit_ff];
    wire         data_bit  = wdata_ff[bit_ff];

    always_comb begin
        is_rd_cyc = (state_ff == ST_RDSET) || (state_ff == ST_DATA && !mode_wr_ff);
        cur_bit   = (state_ff == ST_KEY) ? key_bit : data_bit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            bit_ff   <= 6'h00;
            stage_ff <= 2'd0;
            tick_ff  <= 8'h00;
            phase_ff <= 1'b0;
            done_ff  <= 1'b0;
            rdata_ff <= {RST_ZERO, RST_ZERO};
            ce_n     <= 1'b1;
            oe_n     <= 1'b1;
            we_n     <= 1'b1;
            mem_addr <= RST_ADDR;
            dq0_out  <= 1'b0;
            dq0_oe   <= 1'b0;
        end else begin
            if (ap_rd_ff && ap_ofs_ff == OFS_STATUS)
                done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (go) begin
                        state_ff <= ST_RDSET;
                        bit_ff   <= 6'h00;
                        stage_ff <= 2'd0;
                        phase_ff <= 1'b0;
                        tick_ff  <= 8'h00;
                        done_ff  <= 1'b0;
                        mem_addr <= addr_ff;
                    end
                end
                ST_RDSET, ST_KEY, ST_DATA: begin
                    if (!phase_ff) begin
                        ce_n     <= 1'b0;
                        oe_n     <= !is_rd_cyc;
                        we_n     <= is_rd_cyc;
                        dq0_oe   <= !is_rd_cyc;
                        dq0_out  <= cur_bit;
                        phase_ff <= 1'b1;
                        tick_ff  <= 8'(PULSE_CYCLES - 1);
                    end else if (!tick_end) begin
                        tick_ff <= tick_ff - 8'h01;
                    end else begin
                        ce_n     <= 1'b1;
                        oe_n     <= 1'b1;
                        we_n     <= 1'b1;
                        phase_ff <= 1'b0;
                        tick_ff  <= 8'(RECOV_CYCLES - 1);
                        if (state_ff == ST_DATA && !mode_wr_ff)
                            rdata_ff[bit_ff] <= dq_s2_ff;
                        state_ff <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    dq0_oe <= 1'b0;
                    if (!tick_end)
                        tick_ff <= tick_ff - 8'h01;
                end
                ST_DONE: begin
                    // Set wins over a same-cycle status read clear
                    done_ff  <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
            // Advance the stream after each recovery
            if (state_ff == ST_RECOV && tick_end) begin
                case (stage_ff)
                    2'd0: begin
                        stage_ff <= 2'd1;
                        bit_ff   <= 6'h00;
                        state_ff <= ST_KEY;
                    end
                    2'd1: begin
                        bit_ff   <= bit_ff + 6'h01;
                        // key of 64 writes, then data
                        state_ff <= ST_KEY;
                        if (last_bit) begin
                            stage_ff <= 2'd2;
                            state_ff <= ST_DATA;
                        end
                    end
                    2'd2: begin
                        bit_ff   <= bit_ff + 6'h01;
                        state_ff <= ST_DATA;
                        if (last_bit) begin
                            stage_ff <= 2'd0;
                            state_ff <= ST_DONE;
                        end
                    end
                    default: begin
                        stage_ff <= 2'd0;
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : sttk_host
`default_nettype wire

// file: hdl/sttk_pkg.sv
// Package for the host-side timekeeper controller.
// Assumes a 20 MHz hclk and a serial timekeeper reached by SRAM cycles.
package sttk_pkg;
    // ------------------------------------------------------------------
    // Host register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS = 8'h04;
    localparam logic [7:0]  OFS_TIME_LO = 8'h08;
    localparam logic [7:0]  OFS_TIME_HI = 8'h0C;
    localparam logic [7:0]  OFS_ADDR   = 8'h10;
    // Control bit positions
    localparam int          CTRL_GO_BIT    = 0;
    localparam int          CTRL_WRITE_BIT = 1;
    // Status bit positions
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_DONE_BIT  = 1;
    // ------------------------------------------------------------------
    // Serial stream layout
    // ------------------------------------------------------------------
    localparam int          REG_COUNT   = 8;
    localparam int          REG_BITS    = 8;
    localparam int          FRAME_BITS  = 64;
    localparam logic [63:0] UNLOCK_KEY  = 64'h5CA33AC55CA33AC5;
    // Day register control bits
    localparam int          DAY_RSTIGN_BIT = 4;
    localparam int          DAY_OSCOFF_BIT = 5;
    // Hour register bits
    localparam int          HR_FMT_BIT  = 7;
    localparam int          HR_MER_BIT  = 5;
    // Reset values
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [12:0] RST_ADDR    = 13'h0000;
    // ------------------------------------------------------------------
    // Pin timing at 20 MHz
    // ------------------------------------------------------------------
    localparam int          CLK_NS      = 50;
    localparam int          T_PULSE_NS  = 150;
    localparam int          T_RECOV_NS  = 50;
    localparam int          PULSE_CYC   = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RECOV_CYC   = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [12:0] addr;
        logic        dq0_out;
        logic        dq0_oe;
    } sttk_pins_s;
endpackage : sttk_pkg

// file: dv/sttk_dev_model.sv
// Behavioural serial timekeeper reached through SRAM strobes.
// Assumes the bench resolves lane 0 from the host enable dq0_oe.
`timescale 1ns/100ps
`default_nettype none
module sttk_dev_model import sttk_pkg::*; (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [12:0] addr,
    input  wire logic        dq,
    output var  logic        dev_oe,
    output var  logic        dev_dq
);
    localparam logic [63:0] KEEP = 64'hFF1F3F37BF7F7FFF;
    logic [63:0] regs = 64'h0000_0030_0000_0000;
    logic [6:0]  ptr  = 7'h00;
    logic [5:0]  cnt  = 6'h00;
    logic        shut = 1'b1;
    logic        junk = 1'b0;
    logic [12:0] last_addr;
    wire         rd = !ce_n && !oe_n;
    wire         wr = !ce_n && !we_n;
    // abort pin held high by its pull-up; gated by day bit 4
    wire         abort_n = 1'b1;
    wire         abort   = !regs[36] && !abort_n;
    // Undriven lane keeps changing
    always #25 junk = ~junk;
    assign dev_oe = rd && ptr == 7'h40;
    assign dev_dq = dev_oe ? regs[cnt] : junk;
    always @(negedge rd) begin
        if (ptr != 7'h40) begin
            ptr = 7'h00;
            shut = 1'b0;
        end else begin
            cnt = cnt + 6'h01;
            if (cnt == 6'h00) begin
                ptr = 7'h00;
                shut = 1'b1;
            end
        end
    end
    always @(negedge wr) begin
        last_addr = addr;
        if (abort) begin
            ptr = 7'h00;
            shut = 1'b1;
        end else if (ptr == 7'h40) begin
            regs[cnt] = dq & KEEP[cnt];
            cnt = cnt + 6'h01;
            if (cnt == 6'h00) begin
                ptr = 7'h00;
                shut = 1'b1;
            end
        end else if (!shut && dq === UNLOCK_KEY[ptr[5:0]]) ptr = ptr + 7'h01;
        else shut = 1'b1;
    end
endmodule : sttk_dev_model
`default_nettype wire

// file: dv/sttk_host_asserts.sv
// Checker for the timekeeper host pins and bus answer.
// Bound into sttk_host; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sttk_host_asserts #(
    parameter int PULSE_CYCLES = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic dq0_oe
);
    logic [7:0] wr_cnt_ff;
    logic [7:0] low_cnt_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_cnt_ff <= 8'h00;
        else if (!oe_n) wr_cnt_ff <= 8'h00;
        else if ($fell(we_n) && wr_cnt_ff != 8'hFF) wr_cnt_ff <= wr_cnt_ff + 8'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) low_cnt_ff <= 8'h00;
        else low_cnt_ff <= (we_n && oe_n) ? 8'h00 : low_cnt_ff + 8'h01;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    a_strobe_excl: assert property (!(!oe_n && !we_n))
        else $error("oe_n and we_n low together");
    a_ce_frames: assert property ((!oe_n || !we_n) |-> !ce_n)
        else $error("strobe without ce_n");
    a_read_released: assert property (!oe_n |-> !dq0_oe)
        else $error("lane driven during read");
    a_write_driven: assert property (!we_n |-> dq0_oe)
        else $error("lane not driven during write");
    a_pulse_width: assert property ($rose(we_n && oe_n) |-> low_cnt_ff == PULSE_CYCLES)
        else $error("strobe pulse length wrong");
    a_key_unbroken: assert property ($fell(oe_n) |-> wr_cnt_ff == 8'h00 || wr_cnt_ff >= 8'h40)
        else $error("read inside key sequence");
endmodule : sttk_host_asserts
bind sttk_host sttk_host_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) i_asserts (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .dq0_oe(dq0_oe));
`default_nettype wire

// file: dv/sttk_host_test.sv
// Testbench for sttk_host with a behavioural timekeeper.
// Assumes AHB-Lite single word transfers and one slave.
`timescale 1ns/100ps
`default_nettype none
module sttk_host_test import sttk_pkg::*; ;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic        hreadyout, hresp, ce_n, oe_n, we_n, dq0_out, dq0_oe, dev_oe, dev_dq;
    logic [12:0] mem_addr;
    int          n_errors = 0;
    int          n_checks = 0;
    wire         lane = dq0_oe ? dq0_out : dev_dq;
    sttk_host i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .mem_addr(mem_addr), .dq0_out(dq0_out), .dq0_oe(dq0_oe), .dq0_in(lane));
    sttk_dev_model i_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(mem_addr),
        .dq(lane), .dev_oe(dev_oe), .dev_dq(dev_dq));
    initial forever #25 hclk = ~hclk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            finish_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (q[STAT_DONE_BIT] !== 1'b1 && n < 1000);
        if (q[STAT_DONE_BIT] !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status after done", q, 64'h0);
    endtask : wait_done
    task automatic t_reset();
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status", q, 64'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 64'h0);
        chk("hresp", hresp, 64'h0);
        chk("idle pins", {ce_n, oe_n, we_n, dq0_oe}, 64'hE);
        $display("test reset done");
    endtask : t_reset
    task automatic t_delivery();
        bus(1'b1, OFS_CTRL, 32'h1);
        wait_done();
        bus(1'b0, OFS_TIME_LO, 32'h0);
        chk("time lo", q, 64'h0);
        bus(1'b0, OFS_TIME_HI, 32'h0);
        chk("time hi", q, 64'h30);
        $display("test delivery done");
    endtask : t_delivery
    task automatic t_trip(input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] elo, input logic [31:0] ehi,
                          input logic [12:0] a);
        bus(1'b1, OFS_TIME_LO, lo);
        bus(1'b1, OFS_TIME_HI, hi);
        bus(1'b1, OFS_ADDR, {19'h0, a});
        bus(1'b1, OFS_CTRL, 32'h3);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("busy", q[STAT_BUSY_BIT], 64'h1);
        bus(1'b1, OFS_TIME_LO, 32'h0);
        wait_done();
        chk("device regs", i_dev.regs, {ehi, elo});
        chk("scratch addr", i_dev.last_addr, a);
        bus(1'b1, OFS_CTRL, 32'h1);
        wait_done();
        bus(1'b0, OFS_TIME_LO, 32'h0);
        chk("read lo", q, elo);
        bus(1'b0, OFS_TIME_HI, 32'h0);
        chk("read hi", q, ehi);
        $display("test round trip done");
    endtask : t_trip
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_delivery();
        t_trip(32'hF2D9D999, 32'h99F2F1F7, 32'hB2595999, 32'h99123137, 13'h1ABC);
        t_trip(32'h23000000, 32'h00010121, 32'h23000000, 32'h00010121, 13'h0001);
        finish_test();
    end
endmodule : sttk_host_test
`default_nettype wire
